// File: dv/lss_props.sv
// Port checker for the load status summary block.
// Assumes it is bound into lss_top and shares its clock and reset.
`timescale 1ns/100ps
module lss_props
#(
  parameter int NUM_UNITS = 15
)
(
  input wire logic core_clk_i, // Clock.
  input wire logic rst_n_i, // Reset.
  input wire lss_pkg::lss_fault_t [NUM_UNITS-1:0] fault_i, // Faults.
  input wire logic ques_summary_i, // Questionable.
  input wire logic msg_avail_i, // Message waiting.
  input wire logic std_event_sum_i, // Standard event.
  input wire logic oper_event_i, // Operation event.
  input wire logic cmd_valid_i, // Command strobe.
  input wire lss_pkg::lss_cmd_t cmd_i, // Command.
  input wire logic rsp_valid_o, // Response strobe.
  input wire lss_pkg::lss_rsp_t rsp_o, // Response.
  input wire logic [15:0] unit_summary_o, // Summary.
  input wire logic [7:0] status_byte_o, // Status byte.
  input wire logic srq_o // Service request.
);
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  a_rsp_follows_cmd: assert property (cmd_valid_i |=> rsp_valid_o)
    else $error("command got no response");
  a_rsp_idle_zero: assert property (!rsp_valid_o |-> rsp_o == '0)
    else $error("response data outside a response");
  a_sum_unused_zero: assert property (unit_summary_o[15:NUM_UNITS] == '0)
    else $error("summary bit without a unit is set");
  a_stb_spare_zero: assert property (status_byte_o[1:0] == 2'b00)
    else $error("status byte spare bit set");
  a_srq_is_mss: assert property (srq_o == status_byte_o[6]
    && (!srq_o || (status_byte_o & 8'hBC) != 8'h00))
    else $error("service request differs from summary bit or has no cause");
  a_mav_follows: assert property ($past(rst_n_i, 2) |->
    status_byte_o[4] == $past(msg_avail_i)) else $error("message bit wrong");
  a_stb_inputs: assert property ($past(rst_n_i, 2) |->
    status_byte_o[7] == $past(oper_event_i) && status_byte_o[5] == $past(std_event_sum_i)
    && status_byte_o[3] == $past(ques_summary_i)) else $error("status byte input bit wrong");
  a_unit_sum_cause: assert property ($rose(status_byte_o[2]) |->
    $past(unit_summary_o) != 16'h0000) else $error("unit bit rose without a summary");
  a_bad_unit_err: assert property (cmd_valid_i && cmd_i.op <= lss_pkg::OP_WR_ENABLE
    && cmd_i.unit >= NUM_UNITS |=> rsp_o.err && rsp_o.data == 16'h0000)
    else $error("missing unit not refused");
  a_stb_read_high: assert property (cmd_valid_i && cmd_i.op == lss_pkg::OP_RD_STB
    |=> !rsp_o.err && rsp_o.data[15:8] == 8'h00) else $error("status byte read wrong");
  c_event_read: cover property (cmd_valid_i && cmd_i.op == lss_pkg::OP_RD_EVENT);
  c_unit_sum: cover property ($rose(status_byte_o[2]));
  c_srq: cover property ($rose(srq_o));
endmodule
bind lss_top lss_props #(.NUM_UNITS(NUM_UNITS)) i_props
(
  .core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i),
  .fault_i(fault_i),
  .ques_summary_i(ques_summary_i),
  .msg_avail_i(msg_avail_i),
  .std_event_sum_i(std_event_sum_i),
  .oper_event_i(oper_event_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_i(cmd_i),
  .rsp_valid_o(rsp_valid_o),
  .rsp_o(rsp_o),
  .unit_summary_o(unit_summary_o),
  .status_byte_o(status_byte_o),
  .srq_o(srq_o)
);

// File: dv/lss_top_test.sv
// Self-checking bench for the load status summary block.
// Assumes lss_pkg and lss_top compiled first; drives every port itself.
`timescale 1ns/100ps
module lss_top_test;
  localparam int NU = 4;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  lss_pkg::lss_fault_t [NU-1:0] fault_i = '0;
  logic ques_summary_i = 1'b0;
  logic msg_avail_i = 1'b0;
  logic std_event_sum_i = 1'b0;
  logic oper_event_i = 1'b0;
  logic cmd_valid_i = 1'b0;
  lss_pkg::lss_cmd_t cmd_i = '0;
  logic rsp_valid_o;
  lss_pkg::lss_rsp_t rsp_o;
  logic [15:0] unit_summary_o;
  logic [7:0] status_byte_o;
  logic srq_o;
  int bad_count = 0;
  int cmp_count = 0;
  logic [31:0] seed = 32'h6A934CF8;
  lss_pkg::lss_fault_t [NU-1:0] fl;
  lss_pkg::lss_rsp_t r;
  logic [15:0] sum;
  logic [7:0] sre;
  logic [7:0] es;
  lss_top #(.NUM_UNITS(NU)) i_dut
  (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .fault_i(fault_i),
    .ques_summary_i(ques_summary_i),
    .msg_avail_i(msg_avail_i),
    .std_event_sum_i(std_event_sum_i),
    .oper_event_i(oper_event_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_i(cmd_i),
    .rsp_valid_o(rsp_valid_o),
    .rsp_o(rsp_o),
    .unit_summary_o(unit_summary_o),
    .status_byte_o(status_byte_o),
    .srq_o(srq_o)
  );
  always #20 core_clk_i = ~core_clk_i;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [15:0] exp_cond(input lss_pkg::lss_fault_t f);
    return {2'b00, f.protection_shutdown_flag, f.overvoltage_flag, 7'h00,
      f.overtemperature_flag, f.overpower_flag, 1'b0, f.overcurrent_flag, f.voltage_fault_flag};
  endfunction
  function automatic logic [7:0] exp_stb(input logic [3:0] ins, input logic u, input logic [7:0] m);
    logic [7:0] b;
    b = {ins[3], 1'b0, ins[2], ins[1], ins[0], u, 2'b00};
    return b | {1'b0, |(b & m), 6'h00};
  endfunction
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wait_n(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  task automatic do_cmd(input logic [3:0] op, input logic [3:0] u, input logic [15:0] wd);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_i <= '{op: lss_pkg::lss_op_t'(op), unit: u, wdata: wd};
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    @(negedge core_clk_i);
    chk({23'h0, rsp_valid_o}, 24'h1);
    r = rsp_o;
  endtask
  task automatic test_done();
    if (bad_count == 0 && cmp_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  initial
  begin
    #400000;
    bad_count++;
    test_done();
  end
  initial
  begin
    repeat (5) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    wait_n(1);
    chk({unit_summary_o, status_byte_o}, 24'h0);
    do_cmd(4'h8, 4'h0, 16'h0000);
    chk(r, 24'h0);
    for (int u = 0; u < NU; u++)
    begin
      seed = lfsr(seed);
      do_cmd(4'h3, u[3:0], seed[15:0]);
      do_cmd(4'h2, u[3:0], 16'h0000);
      chk(r, {8'h0, seed[15:0] & 16'h301B});
      do_cmd(4'h3, u[3:0], 16'hFFFF);
    end
    do_cmd(4'h6, 4'h0, 16'hFFFF);
    do_cmd(4'h5, 4'h0, 16'h0000);
    chk(r, 24'h7FFF);
    do_cmd(4'h9, 4'h0, 16'h00FF);
    do_cmd(4'h0, 4'h4, 16'h0000);
    chk(r, 24'h10000);
    do_cmd(4'hF, 4'h0, 16'h0000);
    chk({23'h0, r.err}, 24'h1);
    for (int it = 0; it < 9; it++)
    begin
      sum = 16'h0000;
      for (int u = 0; u < NU; u++)
      begin
        seed = lfsr(seed);
        fl[u] = (it == 0) ? 6'h3F : seed[5:0];
        sum[u] = |exp_cond(fl[u]);
      end
      @(posedge core_clk_i);
      fault_i <= fl;
      wait_n(8);
      chk(unit_summary_o, sum);
      chk(status_byte_o, exp_stb(4'h0, |sum, 8'hFC));
      chk({23'h0, srq_o}, {23'h0, |sum});
      do_cmd(4'h4, 4'h0, 16'h0000);
      chk(r, {8'h0, sum});
      for (int u = 0; u < NU; u++)
      begin
        do_cmd(4'h0, u[3:0], 16'h0000);
        chk(r, exp_cond(fl[u]));
        do_cmd(4'h1, u[3:0], 16'h0000);
        chk(r, exp_cond(fl[u]));
      end
      wait_n(3);
      chk(unit_summary_o, 16'h0000);
      @(posedge core_clk_i);
      fault_i <= '0;
      wait_n(8);
      for (int u = 0; u < NU; u++)
      begin
        do_cmd(4'h1, u[3:0], 16'h0000);
        chk(r, 24'h0);
      end
    end
    for (int i = 0; i < 16; i++)
    begin
      seed = lfsr(seed);
      sre = seed[7:0];
      do_cmd(4'h9, 4'h0, {8'h00, sre});
      @(posedge core_clk_i);
      {oper_event_i, std_event_sum_i, msg_avail_i, ques_summary_i} <= i[3:0];
      es = exp_stb(i[3:0], 1'b0, sre);
      wait_n(3);
      chk(status_byte_o, es);
      chk({23'h0, srq_o}, {23'h0, es[6]});
      do_cmd(4'h7, 4'h0, 16'h0000);
      chk(r, {16'h0, es});
      do_cmd(4'h8, 4'h0, 16'h0000);
      chk(r, {16'h0, sre & 8'hFC});
    end
    test_done();
  end
endmodule

// File: rtl/lss_pkg.sv
// Constants and types for the load status summary block.
// Assumes every user includes nothing and names items as lss_pkg::name.
package lss_pkg;

  localparam int UNITS_MAX = 15;
  localparam int REG_W = 16;
  localparam int STB_W = 8;
  localparam int UNIT_IDX_W = 4;

  // Unit fault status bit positions.
  localparam int VOLTAGE_FAULT_BIT = 0;
  localparam int OVERCURRENT_BIT = 1;
  localparam int OVERPOWER_BIT = 3;
  localparam int OVERTEMPERATURE_BIT = 4;
  localparam int OVERVOLTAGE_BIT = 12;
  localparam int PROT_SHUTDOWN_BIT = 13;
  localparam logic [15:0] UNIT_VALID_MASK = 16'h301B;

  // Unit summary: bit 0 master, bits 1 to 14 slaves, bit 15 unused.
  localparam int SUMMARY_SPARE_BIT = 15;

  // Status byte bit positions.
  localparam int STB_UNIT_SUM_BIT = 2;
  localparam int STB_QUES_BIT = 3;
  localparam int STB_MAV_BIT = 4;
  localparam int STB_ESB_BIT = 5;
  localparam int STB_MSS_BIT = 6;
  localparam int STB_OPER_BIT = 7;
  localparam logic [7:0] STB_VALID_MASK = 8'hFC;

  // Reset values.
  localparam logic [15:0] REG16_RST = 16'h0000;
  localparam logic [15:0] UNIT_ENABLE_RST = 16'h0000;
  localparam logic [15:0] SUMMARY_ENABLE_RST = 16'h0000;
  localparam logic [7:0] STB_RST = 8'h00;
  localparam logic [7:0] SRE_RST = 8'h00;

  // Fault flags reported by one load unit.
  typedef struct packed {
    logic protection_shutdown_flag;
    logic overvoltage_flag;
    logic overtemperature_flag;
    logic overpower_flag;
    logic overcurrent_flag;
    logic voltage_fault_flag;
  } lss_fault_t;

  // Register access operations.
  typedef enum logic [3:0] {
    OP_RD_COND = 4'h0,
    OP_RD_EVENT = 4'h1,
    OP_RD_ENABLE = 4'h2,
    OP_WR_ENABLE = 4'h3,
    OP_RD_SUMMARY = 4'h4,
    OP_RD_SUM_ENABLE = 4'h5,
    OP_WR_SUM_ENABLE = 4'h6,
    OP_RD_STB = 4'h7,
    OP_RD_SRE = 4'h8,
    OP_WR_SRE = 4'h9
  } lss_op_t;

  typedef struct packed {
    lss_op_t op;
    logic [UNIT_IDX_W-1:0] unit;
    logic [REG_W-1:0] wdata;
  } lss_cmd_t;

  typedef struct packed {
    logic err;
    logic [REG_W-1:0] data;
  } lss_rsp_t;

endpackage

// File: rtl/lss_top.sv
// Status summary of a load made of a master unit and parallel slaves.
// Assumes fault flags arrive asynchronously from the units and that the
// command port and the other summary inputs come from core_clk_i logic.
//
// Overview of operation
// - Each load unit has its own fault status register tracking its condition.
// - Bit 0 flags a voltage fault, bit 1 flags detected overcurrent.
// - Bit 3 flags drawn power above the unit's rated maximum.
// - Bit 4 flags a detected overtemperature in that unit.
// - Bit 12 flags a detected input overvoltage at that unit.
// - Bit 13 flags that the unit performed a protective shutdown.
// - Bits 2, 5 to 11, 14 and 15 of unit status read zero.
// - Summary holds one OR bit per unit, master bit 0, bit 15 zero.
// - Status byte gathers service request conditions; bits 0 and 1 read zero.
// - Status byte bit 2 is OR of enabled unit summary bits.
// - Status byte bit 3 is OR of enabled questionable conditions.
// - Status byte bit 4 is set while a message waits in the queue.
// - Status byte bit 5 is set when an enabled standard event occurs.
// - Status byte bit 6 carries the master status summary.
// - Status byte bit 7 is set when an operation status event occurs.
// - Unit, event, enable and summary registers are 16 bits; status byte 8.
// - Each unit has a clear-on-read event register and an enable register.
`timescale 1ns/100ps
module lss_top
#(
  parameter int NUM_UNITS = 15 // Master plus slaves.
)
(
  input wire logic core_clk_i, // Core clock, 25 MHz.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire lss_pkg::lss_fault_t [NUM_UNITS-1:0] fault_i, // Unit fault flags.
  input wire logic ques_summary_i, // Questionable set summary.
  input wire logic msg_avail_i, // Message queue not empty.
  input wire logic std_event_sum_i, // Enabled standard event summary.
  input wire logic oper_event_i, // Operation status summary.
  input wire logic cmd_valid_i, // Command strobe.
  input wire lss_pkg::lss_cmd_t cmd_i, // Command.
  output logic rsp_valid_o, // Response strobe.
  output lss_pkg::lss_rsp_t rsp_o, // Response data and error.
  output logic [15:0] unit_summary_o, // Unit summary register.
  output logic [7:0] status_byte_o, // Status byte register.
  output logic srq_o // Service request.
);

  // The summary register has fifteen unit positions; bit 15 stays spare.
  generate
    if (NUM_UNITS < 1 || NUM_UNITS > lss_pkg::UNITS_MAX)
    begin : g_bad_units
      $error("NUM_UNITS must lie between 1 and 15.");
    end
    // The bit maps below are written for 16-bit registers and an 8-bit byte.
    if (lss_pkg::REG_W != 16 || lss_pkg::STB_W != 8)
    begin : g_bad_widths
      $error("Register widths must stay at 16 and 8 bits.");
    end
    if ((2 ** lss_pkg::UNIT_IDX_W) < NUM_UNITS)
    begin : g_bad_index
      $error("The unit field of a command is too narrow for NUM_UNITS.");
    end
  endgenerate

  lss_pkg::lss_fault_t [NUM_UNITS-1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic [15:0] unit_cond [NUM_UNITS];
  logic [15:0] unit_event [NUM_UNITS];
  logic [15:0] unit_enable [NUM_UNITS];
  logic [NUM_UNITS-1:0] unit_sum;
  logic [NUM_UNITS-1:0] ev_rd;
  logic [NUM_UNITS-1:0] en_wr;
  logic unit_ok;

  // Fault flags come from the units' own analogue domain. Only the second
  // stage feeds the condition logic, since the first may be metastable.
  always_comb
  begin
    sync1_d = fault_i;
    sync2_d = sync1_q;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  // Unit operations name a unit; an index past the last unit is refused.
  assign unit_ok = (32'(cmd_i.unit) < NUM_UNITS);

  generate
    for (genvar u = 0; u < NUM_UNITS; u++)
    begin : g_unit
      // Only the six defined flags reach the condition word; the rest stay zero.
      logic [15:0] cond;

      always_comb
      begin
        cond = 16'h0000;
        cond[lss_pkg::VOLTAGE_FAULT_BIT] = sync2_q[u].voltage_fault_flag;
        cond[lss_pkg::OVERCURRENT_BIT] = sync2_q[u].overcurrent_flag;
        cond[lss_pkg::OVERPOWER_BIT] = sync2_q[u].overpower_flag;
        cond[lss_pkg::OVERTEMPERATURE_BIT] = sync2_q[u].overtemperature_flag;
        cond[lss_pkg::OVERVOLTAGE_BIT] = sync2_q[u].overvoltage_flag;
        cond[lss_pkg::PROT_SHUTDOWN_BIT] = sync2_q[u].protection_shutdown_flag;
      end

      // A read of the event register is also its clear strobe.
      assign ev_rd[u] = cmd_valid_i && (cmd_i.op == lss_pkg::OP_RD_EVENT)
        && (32'(cmd_i.unit) == u);
      assign en_wr[u] = cmd_valid_i && (cmd_i.op == lss_pkg::OP_WR_ENABLE)
        && (32'(cmd_i.unit) == u);

      lss_unit_status u_status
      (
        .core_clk_i(core_clk_i),
        .rst_n_i(rst_n_i),
        .cond_i(cond),
        .ev_rd_i(ev_rd[u]),
        .en_wr_i(en_wr[u]),
        .en_wdata_i(cmd_i.wdata),
        .cond_o(unit_cond[u]),
        .event_o(unit_event[u]),
        .enable_o(unit_enable[u]),
        .summary_o(unit_sum[u])
      );
    end
  endgenerate

  // Summary, its enable, the status byte and the service request mask.
  logic [15:0] summary_q, summary_d;
  logic [15:0] sum_en_q, sum_en_d;
  logic [7:0] stb_q, stb_d;
  logic [7:0] sre_q, sre_d;

  always_comb
  begin
    // Unit positions past the last unit read as zero.
    summary_d = 16'h0000;
    summary_d[NUM_UNITS-1:0] = unit_sum;
    summary_d[lss_pkg::SUMMARY_SPARE_BIT] = 1'b0;
    sum_en_d = sum_en_q;
    if (cmd_valid_i && cmd_i.op == lss_pkg::OP_WR_SUM_ENABLE)
    begin
      sum_en_d = cmd_i.wdata;
      sum_en_d[lss_pkg::SUMMARY_SPARE_BIT] = 1'b0;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      summary_q <= lss_pkg::REG16_RST;
      sum_en_q <= lss_pkg::SUMMARY_ENABLE_RST;
    end
    else
    begin
      summary_q <= summary_d;
      sum_en_q <= sum_en_d;
    end
  end

  // The status byte looks at the registered summary, so it trails it by a cycle.
  always_comb
  begin
    sre_d = sre_q;
    if (cmd_valid_i && cmd_i.op == lss_pkg::OP_WR_SRE)
    begin
      sre_d = cmd_i.wdata[7:0] & lss_pkg::STB_VALID_MASK;
    end
    stb_d = lss_pkg::STB_RST;
    stb_d[lss_pkg::STB_UNIT_SUM_BIT] = |(summary_q & sum_en_q);
    stb_d[lss_pkg::STB_QUES_BIT] = ques_summary_i;
    stb_d[lss_pkg::STB_MAV_BIT] = msg_avail_i;
    stb_d[lss_pkg::STB_ESB_BIT] = std_event_sum_i;
    stb_d[lss_pkg::STB_OPER_BIT] = oper_event_i;
    // The summary bit itself never feeds back into its own term.
    stb_d[lss_pkg::STB_MSS_BIT] =
      |(stb_d & sre_q & ~(8'h01 << lss_pkg::STB_MSS_BIT));
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      stb_q <= lss_pkg::STB_RST;
      sre_q <= lss_pkg::SRE_RST;
    end
    else
    begin
      stb_q <= stb_d;
      sre_q <= sre_d;
    end
  end

  // Command answers, one cycle after the strobe. Outside a response the
  // data lines rest at zero, so a stray sample never shows stale data.
  logic rsp_valid_q, rsp_valid_d;
  lss_pkg::lss_rsp_t rsp_q, rsp_d;
  logic [15:0] sel_cond, sel_event, sel_enable;
  // A unit index past the last unit selects nothing, so all three stay zero.

  always_comb
  begin
    sel_cond = 16'h0000;
    sel_event = 16'h0000;
    sel_enable = 16'h0000;
    for (int i = 0; i < NUM_UNITS; i++)
    begin
      if (32'(cmd_i.unit) == i)
      begin
        sel_cond = unit_cond[i];
        sel_event = unit_event[i];
        sel_enable = unit_enable[i];
      end
    end
  end

  always_comb
  begin
    rsp_valid_d = cmd_valid_i;
    rsp_d = '0;
    if (cmd_valid_i)
    begin
      case (cmd_i.op)
        lss_pkg::OP_RD_COND:
        begin
          rsp_d.data = sel_cond;
          rsp_d.err = !unit_ok;
        end
        lss_pkg::OP_RD_EVENT:
        begin
          rsp_d.data = sel_event;
          rsp_d.err = !unit_ok;
        end
        lss_pkg::OP_RD_ENABLE:
        begin
          rsp_d.data = sel_enable;
          rsp_d.err = !unit_ok;
        end
        lss_pkg::OP_WR_ENABLE:
        begin
          rsp_d.err = !unit_ok;
        end
        lss_pkg::OP_RD_SUMMARY:
        begin
          rsp_d.data = summary_q;
        end
        lss_pkg::OP_RD_SUM_ENABLE:
        begin
          rsp_d.data = sum_en_q;
        end
        lss_pkg::OP_WR_SUM_ENABLE:
        begin
          rsp_d.data = 16'h0000;
        end
        lss_pkg::OP_RD_STB:
        begin
          rsp_d.data = {8'h00, stb_q};
        end
        lss_pkg::OP_RD_SRE:
        begin
          rsp_d.data = {8'h00, sre_q};
        end
        lss_pkg::OP_WR_SRE:
        begin
          rsp_d.data = 16'h0000;
        end
        default:
        begin
          rsp_d.err = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      rsp_valid_q <= 1'b0;
      rsp_q <= '0;
    end
    else
    begin
      rsp_valid_q <= rsp_valid_d;
      rsp_q <= rsp_d;
    end
  end

  assign rsp_valid_o = rsp_valid_q;
  assign rsp_o = rsp_q;
  assign unit_summary_o = summary_q;
  assign status_byte_o = stb_q;
  // The request follows the registered summary bit, so it never glitches.
  assign srq_o = stb_q[lss_pkg::STB_MSS_BIT];

endmodule

// File: rtl/lss_unit_status.sv
// One unit's fault status set: condition, clear-on-read event, enable.
// Assumes a condition input already synchronised to core_clk_i.
`timescale 1ns/100ps
module lss_unit_status
(
  input wire logic core_clk_i, // Core clock.
  input wire logic rst_n_i, // Asynchronous reset, active low.
  input wire logic [15:0] cond_i, // Present fault condition.
  input wire logic ev_rd_i, // Event register read pulse.
  input wire logic en_wr_i, // Enable register write pulse.
  input wire logic [15:0] en_wdata_i, // Enable write data.
  output logic [15:0] cond_o, // Condition register.
  output logic [15:0] event_o, // Event register.
  output logic [15:0] enable_o, // Enable register.
  output logic summary_o // OR of enabled events.
);

  logic [15:0] cond_q, cond_d;
  logic [15:0] event_q, event_d;
  logic [15:0] enable_q, enable_d;

  always_comb
  begin
    cond_d = cond_i & lss_pkg::UNIT_VALID_MASK;
    // A new rising condition in the read cycle survives the clear.
    event_d = ((ev_rd_i ? lss_pkg::REG16_RST : event_q)
      | (cond_d & ~cond_q)) & lss_pkg::UNIT_VALID_MASK;
    enable_d = en_wr_i ? (en_wdata_i & lss_pkg::UNIT_VALID_MASK) : enable_q;
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      cond_q <= lss_pkg::REG16_RST;
      event_q <= lss_pkg::REG16_RST;
      enable_q <= lss_pkg::UNIT_ENABLE_RST;
    end
    else
    begin
      cond_q <= cond_d;
      event_q <= event_d;
      enable_q <= enable_d;
    end
  end

  assign cond_o = cond_q;
  assign event_o = event_q;
  assign enable_o = enable_q;
  assign summary_o = |(event_q & enable_q);

endmodule
